// ==== rtl/irq_entry_pkg.sv ====
// Package of constants for the core interrupt and reset entry controller.
// Assumes a single core clock domain; no register bus, all bits are ports.
package irq_entry_pkg;

	// ==================================================
	// Condition code layout and reset values
	localparam int          CC_MASK_BIT   = 3;
	localparam logic [7:0]  CC_RESET      = 8'hE8;
	localparam logic [15:0] SP_RESET      = 16'h017F;
	localparam logic [15:0] SP_FORCED     = 16'h0100;
	localparam logic [6:0]  SP_LOW_MASK   = 7'h7F;

	// ==================================================
	// Vectors
	localparam logic [15:0] VEC_RESET_LO  = 16'hFFFE;
	localparam logic [15:0] VEC_RESET_HI  = 16'hFFFF;
	localparam logic [15:0] VEC_TRAP      = 16'hFFFC;
	localparam logic [15:0] VEC_EXT0      = 16'hFFFA;
	localparam logic [15:0] VEC_EXT1      = 16'hFFF8;
	localparam logic [15:0] VEC_STEP      = 16'h0002;

	// ==================================================
	// Source counts and timing
	localparam int          NUM_EXT       = 2;
	localparam int          NUM_PERIPH    = 6;
	localparam int          NUM_SRC       = NUM_EXT + NUM_PERIPH;
	localparam int          PINS_PER_EXT  = 8;
	localparam int          STAB_CYCLES   = 4096;
	localparam int          FETCH_CYCLES  = 2;
	localparam int          STACK_BYTES   = 5;

	// ==================================================
	// External sensitivity encodings
	localparam logic [1:0]  SENS_FALL_LOW = 2'h0;
	localparam logic [1:0]  SENS_RISE     = 2'h1;
	localparam logic [1:0]  SENS_FALL     = 2'h2;
	localparam logic [1:0]  SENS_BOTH     = 2'h3;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_STAB,
		ST_FETCH,
		ST_RUN,
		ST_STACK,
		ST_VECTOR,
		ST_UNSTACK,
		ST_LOWPWR
	} seq_state_t;

endpackage : irq_entry_pkg

// ==== rtl/ext_irq_detect.sv ====
// External interrupt detector for one shared vector.
// Assumes pin inputs already synchronised to core_clk by the caller.
`timescale 1ns/10ps
`default_nettype none

module ext_irq_detect
	import irq_entry_pkg::*;
#(
	parameter int PINS = PINS_PER_EXT
)
(
	input  wire logic            core_clk,
	input  wire logic            nrst,
	input  wire logic [PINS-1:0] pin_level,
	input  wire logic [PINS-1:0] pin_irq_en,
	input  wire logic [1:0]      sens,
	input  wire logic            ack,
	output logic                 req
);

	// ==================================================
	// Combine and detect
	logic comb_level;
	logic comb_reg;
	logic edge_hit;
	logic latch_reg;

	initial
	begin
		if (PINS < 1)
			$error("ext_irq_detect: PINS must be at least 1");
	end

	// low enabled pin forces combined low
	assign comb_level = ~(&(pin_level | ~pin_irq_en)) ? 1'b0 : 1'b1;

	// Previous combined level for edge detection
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			comb_reg <= 1'b1;
		else
			comb_reg <= comb_level;
	end

	always_comb
	begin
		unique case (sens)
			SENS_RISE: edge_hit = comb_level & ~comb_reg;
			SENS_FALL: edge_hit = ~comb_level & comb_reg;
			SENS_BOTH: edge_hit = comb_level ^ comb_reg;
			SENS_FALL_LOW: edge_hit = ~comb_level & comb_reg;
		endcase
	end

	// edge latched, cleared on entry; new edge wins
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			latch_reg <= 1'b0;
		else if (edge_hit)
			latch_reg <= 1'b1;
		else if (ack)
			latch_reg <= 1'b0;
	end

	// Low level mode requests for as long as the level stays low
	assign req = latch_reg | ((sens == SENS_FALL_LOW) & ~comb_level);

endmodule // ext_irq_detect

`default_nettype wire

// ==== rtl/irq_entry.sv ====
// Interrupt and reset entry sequencer of a small 8-bit core.
// Assumes the core presents its context and accepts stack writes and vector loads as ports.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Maskable requests served only with mask clear; otherwise held pending.
// - Any reset leaves the global mask set.
// - Finish instruction, stack context, set mask, load vector, fetch handler.
// - Interrupt return unstacks context, clearing the mask, and resumes.
// - Simultaneous pending requests resolved by fixed priority.
// - Any interrupt wakes wait; only external and marked sources wake halt.
// - Software trap entered regardless of the mask.
// - External vector taken on latched event with mask clear; wakes halt.
// - External sensitivity chosen by miscellaneous register configuration bits.
// - External edges latched and cleared on entry to the handler.
// - Enabled pins sharing one vector are AND combined before detection.
// - A low enabled pin blocks the shared request, even on rising edge.
// - Peripheral flag interrupts need mask clear and enable set; else pending.
// - Peripheral flag clears by writing 0 or status access then associated access.
// - A clearing sequence also discards a pending request.
// - After reset wait 4096 cycles before the vector fetch.
// - Reset vector fetch lasts 2 cycles reading FFFEh and FFFFh.
// - Mask is bit 3 of condition code; set on entry and by software.
// - Stacking takes five bytes, low program counter first, pointer decrements.
module irq_entry
	import irq_entry_pkg::*;
#(
	parameter int STAB_COUNT = STAB_CYCLES,
	parameter int PINS       = PINS_PER_EXT
)
(
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	input  wire logic [PINS-1:0]       pin_a,
	input  wire logic [PINS-1:0]       pin_b,
	input  wire logic [PINS-1:0]       pin_a_irq_en,
	input  wire logic [PINS-1:0]       pin_b_irq_en,
	input  wire logic [1:0]            miscellaneous_control_register_sens0,
	input  wire logic [1:0]            miscellaneous_control_register_sens1,
	input  wire logic [NUM_PERIPH-1:0] periph_event,
	input  wire logic [NUM_PERIPH-1:0] periph_enable,
	input  wire logic [NUM_PERIPH-1:0] periph_halt_wake,
	input  wire logic [NUM_PERIPH-1:0] flag_write_zero,
	input  wire logic [NUM_PERIPH-1:0] status_read,
	input  wire logic [NUM_PERIPH-1:0] assoc_access,
	input  wire logic                  instr_done,
	input  wire logic                  trap_exec,
	input  wire logic                  interrupt_return_instruction_exec,
	input  wire logic                  wait_exec,
	input  wire logic                  halt_exec,
	input  wire logic                  mask_set_sw,
	input  wire logic                  mask_clr_sw,
	input  wire logic [15:0]           program_counter,
	input  wire logic [7:0]            index_x,
	input  wire logic [7:0]            accumulator,
	input  wire logic [7:0]            cc_in,
	input  wire logic [7:0]            stack_rd_data,
	output logic [7:0]                 condition_code_register,
	output logic [15:0]                stack_pointer,
	output logic                       stack_wr,
	output logic [15:0]                stack_addr,
	output logic [7:0]                 stack_wr_data,
	output logic                       vec_rd,
	output logic [15:0]                vec_addr,
	output logic                       pc_load,
	output logic                       ctx_restore,
	output logic [NUM_PERIPH-1:0]      periph_flag,
	output logic                       core_stall,
	output logic                       in_halt,
	output logic                       in_wait,
	output logic                       reset_busy
);

	initial
	begin
		// Stabilisation counter is 13 bits wide
		if (STAB_COUNT < 1 || STAB_COUNT > 8192 || PINS < 1)
			$error("irq_entry: STAB_COUNT must be 1 to 8192 and PINS at least 1");
	end

	// ==================================================
	// Pin synchronisers
	logic [PINS-1:0] a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			a_s1_reg <= '1;
			a_s2_reg <= '1;
			b_s1_reg <= '1;
			b_s2_reg <= '1;
		end
		else
		begin
			a_s1_reg <= pin_a;
			a_s2_reg <= a_s1_reg;
			b_s1_reg <= pin_b;
			b_s2_reg <= b_s1_reg;
		end
	end

	// ==================================================
	// External detectors
	logic [NUM_EXT-1:0] ext_req;
	logic [NUM_EXT-1:0] ext_ack;

	ext_irq_detect #(.PINS(PINS)) u_ext0 (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.pin_level  (a_s2_reg),
		.pin_irq_en (pin_a_irq_en),
		.sens       (miscellaneous_control_register_sens0),
		.ack        (ext_ack[0]),
		.req        (ext_req[0])
	);

	ext_irq_detect #(.PINS(PINS)) u_ext1 (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.pin_level  (b_s2_reg),
		.pin_irq_en (pin_b_irq_en),
		.sens       (miscellaneous_control_register_sens1),
		.ack        (ext_ack[1]),
		.req        (ext_req[1])
	);

	// ==================================================
	// Peripheral flag latches
	logic [NUM_PERIPH-1:0] armed_reg;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PERIPH; gi++)
		begin : g_periph
			// Status read arms the two-step clear
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					armed_reg[gi] <= 1'b0;
				else if (status_read[gi])
					armed_reg[gi] <= periph_flag[gi];
				else if (assoc_access[gi])
					armed_reg[gi] <= 1'b0;
			end

			// write zero or armed access clears
			// clear drops pending request; event wins
			always_ff @(posedge core_clk or negedge nrst)
			begin
				if (!nrst)
					periph_flag[gi] <= 1'b0;
				else if (periph_event[gi])
					periph_flag[gi] <= 1'b1;
				else if (flag_write_zero[gi] || (armed_reg[gi] && assoc_access[gi]))
					periph_flag[gi] <= 1'b0;
			end
		end
	endgenerate

	// ==================================================
	// Request collection and priority
	logic [NUM_SRC-1:0] src_req;
	logic [NUM_SRC-1:0] halt_wake_src;
	logic [NUM_SRC-1:0] win_onehot;
	logic               mask;
	logic               any_req;

	assign mask = condition_code_register[CC_MASK_BIT];

	// peripheral needs its enable; else stays latched
	assign src_req       = {periph_flag & periph_enable, ext_req};
	assign halt_wake_src = {periph_halt_wake, {NUM_EXT{1'b1}}};
	assign any_req       = |src_req;

	assign win_onehot = src_req & (~src_req + NUM_SRC'(1));

	// ==================================================
	// Sequencer
	seq_state_t      state_reg;
	logic [12:0]     cnt_reg;
	logic [2:0]      step_reg;
	logic [15:0]     vector_reg;
	logic            is_halt_reg;
	logic [NUM_SRC-1:0] taken_reg;
	logic            take;

	// external vector needs event and mask clear
	assign take = instr_done && (trap_exec || (!mask && any_req));

	// Vector of the winning source
	function automatic logic [15:0] vec_of(input logic [NUM_SRC-1:0] oh);
		logic [15:0] v;
		v = VEC_EXT0;
		for (int i = 0; i < NUM_SRC; i++)
			if (oh[i])
				v = VEC_EXT0 - VEC_STEP * 16'(i);
		return v;
	endfunction

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg   <= ST_STAB;
			cnt_reg     <= '0;
			step_reg    <= '0;
			vector_reg  <= VEC_RESET_LO;
			is_halt_reg <= 1'b0;
			taken_reg   <= '0;
		end
		else
		begin
			unique case (state_reg)
				ST_STAB:
				begin
					if (cnt_reg == 13'(STAB_COUNT - 1))
					begin
						cnt_reg   <= '0;
						state_reg <= is_halt_reg ? ST_STACK : ST_FETCH;
						step_reg  <= '0;
					end
					else
						cnt_reg <= cnt_reg + 13'd1;
				end
				ST_FETCH:
				begin
					if (step_reg == 3'(FETCH_CYCLES - 1))
						state_reg <= ST_RUN;
					step_reg <= step_reg + 3'd1;
				end
				ST_RUN:
				begin
					step_reg <= '0;
					if (take)
					begin
						taken_reg  <= trap_exec ? '0 : win_onehot;
						vector_reg <= trap_exec ? VEC_TRAP : vec_of(win_onehot);
						state_reg  <= ST_STACK;
					end
					else if (interrupt_return_instruction_exec && instr_done)
						state_reg <= ST_UNSTACK;
					else if ((wait_exec || halt_exec) && instr_done)
					begin
						is_halt_reg <= halt_exec;
						state_reg   <= ST_LOWPWR;
					end
				end
				// wait wakes on any, halt on external or marked ones
				ST_LOWPWR:
				begin
					if (is_halt_reg ? |(src_req & halt_wake_src) : any_req)
					begin
						taken_reg  <= win_onehot;
						vector_reg <= vec_of(win_onehot);
						cnt_reg    <= '0;
						state_reg  <= is_halt_reg ? ST_STAB : ST_STACK;
					end
				end
				ST_STACK:
				begin
					is_halt_reg <= 1'b0;
					if (step_reg == 3'(STACK_BYTES - 1))
						state_reg <= ST_VECTOR;
					step_reg <= step_reg + 3'd1;
				end
				ST_VECTOR:
					state_reg <= ST_RUN;
				ST_UNSTACK:
				begin
					if (step_reg == 3'(STACK_BYTES - 1))
						state_reg <= ST_RUN;
					step_reg <= step_reg + 3'd1;
				end
				default:
					state_reg <= ST_RUN;
			endcase
		end
	end

	assign ext_ack = (state_reg == ST_VECTOR) ? taken_reg[NUM_EXT-1:0] : '0;

	// ==================================================
	// Condition code and mask
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			condition_code_register <= CC_RESET;
		else if (state_reg == ST_UNSTACK && step_reg == 3'd0)
			condition_code_register <= stack_rd_data & ~(8'h01 << CC_MASK_BIT);
		else if (state_reg == ST_STACK && step_reg == 3'(STACK_BYTES - 1))
			condition_code_register <= condition_code_register | (8'h01 << CC_MASK_BIT);
		else if (state_reg == ST_RUN && (wait_exec || halt_exec) && instr_done && !take)
			condition_code_register <= condition_code_register & ~(8'h01 << CC_MASK_BIT);
		else if (state_reg == ST_RUN && mask_set_sw)
			condition_code_register <= cc_in | (8'h01 << CC_MASK_BIT);
		else if (state_reg == ST_RUN && mask_clr_sw)
			condition_code_register <= cc_in & ~(8'h01 << CC_MASK_BIT);
	end

	// ==================================================
	// Stack pointer and data
	logic [15:0] sp_next;

	// Pointer wraps inside the stack window
	assign sp_next = (state_reg == ST_STACK)
		? (SP_FORCED | {9'h000, 7'(stack_pointer[6:0] - 7'd1) & SP_LOW_MASK})
		: (SP_FORCED | {9'h000, 7'(stack_pointer[6:0] + 7'd1) & SP_LOW_MASK});

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			stack_pointer <= SP_RESET;
		else if (state_reg == ST_STACK || state_reg == ST_UNSTACK)
			stack_pointer <= sp_next;
	end

	// Byte order: pcl, pch, x, a, cc
	always_comb
	begin
		unique case (step_reg)
			3'd0: stack_wr_data = program_counter[7:0];
			3'd1: stack_wr_data = program_counter[15:8];
			3'd2: stack_wr_data = index_x;
			3'd3: stack_wr_data = accumulator;
			default: stack_wr_data = condition_code_register;
		endcase
	end

	// Pop addresses the pre-incremented slot
	assign stack_wr    = (state_reg == ST_STACK);
	assign stack_addr  = (state_reg == ST_UNSTACK) ? sp_next : stack_pointer;
	assign ctx_restore = (state_reg == ST_UNSTACK);

	// ==================================================
	// Vector fetch and status
	assign vec_rd      = (state_reg == ST_FETCH) || (state_reg == ST_VECTOR);
	assign vec_addr    = (state_reg == ST_FETCH) ? (step_reg[0] ? VEC_RESET_HI : VEC_RESET_LO) : vector_reg;
	assign pc_load     = (state_reg == ST_VECTOR) || (state_reg == ST_FETCH && step_reg == 3'(FETCH_CYCLES - 1));
	assign core_stall  = (state_reg != ST_RUN);
	assign in_halt     = (state_reg == ST_LOWPWR) && is_halt_reg;
	assign in_wait     = (state_reg == ST_LOWPWR) && !is_halt_reg;
	assign reset_busy  = (state_reg == ST_STAB) && !is_halt_reg;

endmodule // irq_entry

`default_nettype wire

// ==== tb/irq_entry_properties.sv ====
// Concurrent checks on the ports of the interrupt entry sequencer.
// Assumes a bind onto irq_entry and one core_clk domain.
`timescale 1ns/10ps
`default_nettype none

module irq_entry_properties
	import irq_entry_pkg::*;
#(
	parameter int STAB_COUNT = STAB_CYCLES
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic instr_done,
	input wire logic trap_exec,
	input wire logic interrupt_return_instruction_exec,
	input wire logic [15:0] program_counter,
	input wire logic [NUM_PERIPH-1:0] periph_event,
	input wire logic [NUM_PERIPH-1:0] flag_write_zero,
	input wire logic [7:0] condition_code_register,
	input wire logic [15:0] stack_pointer,
	input wire logic stack_wr,
	input wire logic [7:0] stack_wr_data,
	input wire logic vec_rd,
	input wire logic [15:0] vec_addr,
	input wire logic pc_load,
	input wire logic [NUM_PERIPH-1:0] periph_flag,
	input wire logic core_stall
);
	// ====
	// Cycles since release, saturating so it never wraps
	int unsigned since_rst;
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			since_rst <= 0;
		else if (since_rst < STAB_COUNT + 8)
			since_rst <= since_rst + 1;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// ====
	// Reset entry
	AST_MASK_AT_RESET:
	assert property ($rose(nrst) |-> condition_code_register[CC_MASK_BIT]) else $error("mask clear after reset");
	AST_STAB_DELAY:
	assert property (vec_rd && vec_addr == VEC_RESET_LO |-> since_rst >= STAB_COUNT && since_rst <= STAB_COUNT + 2)
		else $error("reset fetch at wrong time");
	AST_FETCH_HI:
	assert property (vec_rd && vec_addr == VEC_RESET_LO |=> vec_addr == VEC_RESET_HI && pc_load)
		else $error("reset fetch not two cycles");

	// ====
	// Interrupt entry and return
	AST_STACK_FIVE:
	assert property ($rose(stack_wr) |-> stack_wr[*5] ##1 !stack_wr) else $error("stacking not five bytes");
	AST_STACK_DEC:
	assert property (stack_wr |=> stack_pointer[6:0] == $past(stack_pointer[6:0]) - 7'h01
		&& stack_pointer[15:7] == SP_FORCED[15:7]) else $error("stack pointer not decremented");
	AST_PCL_FIRST:
	assert property ($rose(stack_wr) |-> stack_wr_data == program_counter[7:0]) else $error("first byte not pcl");
	AST_ENTRY_SEQ:
	assert property ($fell(stack_wr) |-> vec_rd && pc_load && condition_code_register[CC_MASK_BIT])
		else $error("no vector load with mask after stacking");
	AST_MASKED_HOLD:
	assert property ($rose(stack_wr) |-> $past(trap_exec) || !$past(condition_code_register[CC_MASK_BIT]))
		else $error("entry while masked");
	AST_TRAP_ANY:
	assert property (instr_done && trap_exec && !core_stall |=> stack_wr) else $error("trap not entered");
	AST_INTERRUPT_RETURN_INSTRUCTION_UNMASK:
	assert property (instr_done && interrupt_return_instruction_exec && !core_stall |-> ##[1:8] !condition_code_register[CC_MASK_BIT])
		else $error("return left mask set");

	// ====
	// Peripheral flag of source 0
	AST_FLAG_SET:
	assert property (periph_event[0] |=> periph_flag[0]) else $error("flag not latched");
	AST_FLAG_CLEAR:
	assert property (flag_write_zero[0] && !periph_event[0] |=> !periph_flag[0]) else $error("flag not cleared");
endmodule // irq_entry_properties

bind irq_entry irq_entry_properties #(.STAB_COUNT(STAB_COUNT)) u_irq_entry_properties (
	.core_clk(core_clk), .nrst(nrst), .instr_done(instr_done), .trap_exec(trap_exec), .interrupt_return_instruction_exec(interrupt_return_instruction_exec),
	.program_counter(program_counter), .periph_event(periph_event), .flag_write_zero(flag_write_zero),
	.condition_code_register(condition_code_register), .stack_pointer(stack_pointer), .stack_wr(stack_wr),
	.stack_wr_data(stack_wr_data), .vec_rd(vec_rd), .vec_addr(vec_addr), .pc_load(pc_load),
	.periph_flag(periph_flag), .core_stall(core_stall));

`default_nettype wire

// ==== tb/core_model.sv ====
// Behavioural CPU core facing the interrupt entry sequencer.
// Assumes instructions ending on random cycles, a held context and a 128-byte stack.
`timescale 1ns/10ps
`default_nettype none

module core_model
#(
	parameter logic [15:0] PC_VAL = 16'h1000,
	parameter logic [7:0] X_VAL = 8'h00,
	parameter logic [7:0] A_VAL = 8'h00
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic core_stall,
	input wire logic stack_wr,
	input wire logic [15:0] stack_addr,
	input wire logic [7:0] stack_wr_data,
	input wire logic [7:0] condition_code_register,
	output logic instr_done,
	output logic [15:0] program_counter,
	output logic [7:0] index_x,
	output logic [7:0] accumulator,
	output logic [7:0] cc_in,
	output logic [7:0] stack_rd_data
);
	logic [7:0] stack_mem [0:127];

	// Context held still while the sequencer stacks it
	assign program_counter = PC_VAL;
	assign index_x = X_VAL;
	assign accumulator = A_VAL;
	assign cc_in = condition_code_register;
	assign stack_rd_data = stack_mem[stack_addr[6:0]];

	// Random gaps between instruction ends, so entry waits on a slow core too
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			instr_done <= 1'b0;
		else
			instr_done <= !core_stall && ($urandom_range(3) != 0);
	end

	// Stack memory, wraps within the 128 bytes
	always_ff @(posedge core_clk)
	begin
		if (stack_wr)
			stack_mem[stack_addr[6:0]] <= stack_wr_data;
	end
endmodule // core_model

`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the interrupt entry sequencer.
// Assumes core_model on the core side and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module tb;
	import irq_entry_pkg::*;
	localparam int STAB = 8;
	localparam logic [15:0] PC_V = 16'hC3A5;
	localparam logic [7:0] X_V = 8'h5A;
	localparam logic [7:0] A_V = 8'h3C;

	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] pa = 8'hFF, pb = 8'hFF, pae = 8'h00, pbe = 8'h00;
	logic [1:0] s0 = SENS_RISE, s1 = SENS_FALL;
	logic [5:0] en = 6'h00, hw = 6'h00;
	logic [5:0] pp [5] = '{default: 6'h00}; // event, write zero, status, assoc, ops
	wire logic [7:0] cc, swd, xr, acc, ccin, srd;
	wire logic [15:0] sp, sa, va, pc;
	wire logic [5:0] flag;
	wire logic swr, vrd, pcl, ctx, stall, hlt, wt, rbusy, idone;
	int mismatches = 0, checked = 0;
	int k, i, j;

	irq_entry #(.STAB_COUNT(STAB), .PINS(8)) u_irq_entry (.core_clk(core_clk), .nrst(nrst), .pin_a(pa), .pin_b(pb),
		.pin_a_irq_en(pae), .pin_b_irq_en(pbe), .miscellaneous_control_register_sens0(s0),
		.miscellaneous_control_register_sens1(s1), .periph_event(pp[0]), .periph_enable(en), .periph_halt_wake(hw),
		.flag_write_zero(pp[1]), .status_read(pp[2]), .assoc_access(pp[3]), .instr_done(idone),
		.trap_exec(pp[4][0]), .interrupt_return_instruction_exec(pp[4][1]), .mask_clr_sw(pp[4][2]), .mask_set_sw(pp[4][3]),
		.wait_exec(pp[4][4]), .halt_exec(pp[4][5]), .program_counter(pc), .index_x(xr), .accumulator(acc),
		.cc_in(ccin), .stack_rd_data(srd), .condition_code_register(cc), .stack_pointer(sp), .stack_wr(swr),
		.stack_addr(sa), .stack_wr_data(swd), .vec_rd(vrd), .vec_addr(va), .pc_load(pcl), .ctx_restore(ctx),
		.periph_flag(flag), .core_stall(stall), .in_halt(hlt), .in_wait(wt), .reset_busy(rbusy));

	core_model #(.PC_VAL(PC_V), .X_VAL(X_V), .A_VAL(A_V)) u_core_model (.core_clk(core_clk), .nrst(nrst),
		.core_stall(stall), .stack_wr(swr), .stack_addr(sa), .stack_wr_data(swd), .condition_code_register(cc),
		.instr_done(idone), .program_counter(pc), .index_x(xr), .accumulator(acc), .cc_in(ccin),
		.stack_rd_data(srd));

	// ====
	// Clock and watchdog, far beyond the few hundred cycles needed
	initial
		forever #20 core_clk = ~core_clk;
	initial
	begin
		#400000;
		mismatches++;
		give_verdict();
	end

	// ====
	// Helpers
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			#1;
		end
	endtask
	// One-cycle strobe on a peripheral input group
	task automatic pulse(input int g, input logic [5:0] m);
		@(posedge core_clk);
		pp[g] <= m;
		@(posedge core_clk);
		pp[g] <= 6'h00;
		#1;
	endtask
	// Instruction held until the core ends one
	task automatic op(input int b);
		pp[4] <= 6'h01 << b;
		do @(posedge core_clk); while (!(idone && !stall));
		pp[4] <= 6'h00;
		#1;
	endtask
	task automatic quiet(input int n);
		repeat (n)
		begin
			step(1);
			check("no entry", swr, 1'b0);
		end
	endtask
	function automatic logic [15:0] vec_of(input int s);
		return VEC_EXT0 - VEC_STEP * 16'(s);
	endfunction
	// Full entry walk: five stacked bytes then the vector
	task automatic entry(input logic [15:0] vec, input logic [7:0] ccv);
		logic [7:0] b [5];
		b = '{PC_V[7:0], PC_V[15:8], X_V, A_V, ccv};
		repeat (300)
			if (swr !== 1'b1)
				step(1);
		for (int n = 0; n < 5; n++)
		begin
			check("stack byte", swd, b[n]);
			step(1);
		end
		check("vector", va, vec);
		check("vector load", pcl, 1'b1);
	endtask

	// ====
	// Main sequence
	initial
	begin
		void'($urandom(14904));
		repeat (6) @(posedge core_clk);
		#1;
		check("cc reset", cc, CC_RESET);
		check("sp reset", sp, SP_RESET);
		check("busy", rbusy, 1'b1);
		nrst <= 1'b1;
		repeat (60)
			if (pcl !== 1'b1)
				step(1);
		check("reset vector", va, VEC_RESET_HI);
		check("mask after reset", cc[CC_MASK_BIT], 1'b1);
		// Masked peripheral flag, both clearing methods, discard on clear
		k = $urandom_range(5);
		en <= 6'h3F;
		pulse(0, (6'h01 << k) | 6'h01);
		check("flag set", flag, (16'h1 << k) | 16'h1);
		pulse(1, (6'h01 << k) | 6'h01);
		check("write zero", flag, 0);
		pulse(0, 6'h01 << k);
		pulse(2, 6'h01 << k);
		pulse(3, 6'h01 << k);
		check("status clear", flag, 0);
		op(2);
		quiet(20);
		// Two pending at once, lower index first
		op(3);
		i = $urandom_range(4);
		j = $urandom_range(5, i + 1);
		pulse(0, (6'h01 << i) | (6'h01 << j));
		quiet(10);
		op(2);
		entry(vec_of(NUM_EXT + i), 8'hE0);
		pulse(1, 6'h01 << i);
		op(1);
		entry(vec_of(NUM_EXT + j), 8'hE0);
		pulse(1, 6'h01 << j);
		op(1);
		// Trap with the mask set
		op(3);
		op(0);
		entry(VEC_TRAP, 8'hE8);
		op(1);
		check("unstack", ctx, 1'b1);
		step(8);
		check("cc after return", cc, 8'hE0);
		// Wait and halt wake-up
		op(4);
		check("in wait", wt, 1'b1);
		pulse(0, 6'h01 << k);
		entry(vec_of(NUM_EXT + k), 8'hE0);
		pulse(1, 6'h01 << k);
		op(1);
		op(5);
		pulse(0, 6'h01 << k);
		step(20);
		check("halt held", hlt, 1'b1);
		hw <= 6'h01 << k;
		entry(vec_of(NUM_EXT + k), 8'hE0);
		pulse(1, 6'h01 << k);
		hw <= 6'h00;
		op(1);
		// Shared pins: a low enabled pin blocks rising edges
		en <= 6'h00;
		pa <= 8'hFD;
		pae <= 8'h03;
		step(6);
		pa <= 8'hFC;
		step(4);
		pa <= 8'hFD;
		quiet(20);
		pa <= 8'hFF;
		entry(VEC_EXT0, 8'hE0);
		op(1);
		quiet(20);
		// Falling edge latched while masked
		op(3);
		pbe <= 8'h01;
		step(2);
		pb <= 8'hFE;
		quiet(20);
		op(2);
		entry(VEC_EXT1, 8'hE0);
		op(1);
		quiet(20);
		// Both edges: the release of the pin also requests
		s1 <= SENS_BOTH;
		step(2);
		pb <= 8'hFF;
		entry(VEC_EXT1, 8'hE0);
		op(1);
		// Low level mode: request follows the level, none after release
		s0 <= SENS_FALL_LOW;
		step(2);
		pa <= 8'hFE;
		entry(VEC_EXT0, 8'hE0);
		pa <= 8'hFF;
		step(4);
		op(1);
		quiet(20);
		give_verdict();
	end
endmodule // tb

`default_nettype wire
